// *** rtl/eeeadv_defs.svh ***
`ifndef EEEADV_DEFS_SVH
`define EEEADV_DEFS_SVH

// Register offsets as printed; the APB byte address comes from EEEADV_BYTE_ADDR
`define EEEADV_LOCAL_ADV_ADDR   16'h8001
`define EEEADV_PARTNER_ADDR     16'h8002
`define EEEADV_ADDR_W           18
// Byte address of a register is four times its printed offset
`define EEEADV_BYTE_ADDR(idx)   {idx, 2'b00}

// Field positions, shared by both registers
`define EEEADV_BIT_FAST_TX      1
`define EEEADV_BIT_GIG_T        2
`define EEEADV_BIT_TENGIG_T     3
`define EEEADV_BIT_GIG_KX       4
`define EEEADV_BIT_TENGIG_KX4   5
`define EEEADV_BIT_TENGIG_KR    6

// Reset values
`define EEEADV_LOCAL_RST_OFF    16'h0000
`define EEEADV_LOCAL_RST_ON     16'h0006
`define EEEADV_PARTNER_RST      16'h0000

// Local register read mask: only the 100BASE-TX bit is ever seen
`define EEEADV_LOCAL_RD_MASK    16'h0002
// Partner register read mask: bits 6 to 1
`define EEEADV_PARTNER_RD_MASK  16'h007e

`endif

// *** rtl/eeeadv_pkg.sv ***
package eeeadv_pkg;
  typedef enum logic [2:0] {
    EEEADV_IDLE   = 3'b001,
    EEEADV_ACCESS = 3'b010,
    EEEADV_DONE   = 3'b100
  } eeeadv_apb_state_t;

  typedef logic [15:0] eeeadv_reg_t;
endpackage

// *** rtl/eeeadv_partner_capture.sv ***
`timescale 1ns/100ps
`include "eeeadv_defs.svh"

// Holds the partner's advertisement as received during autonegotiation.
module eeeadv_partner_capture
  import eeeadv_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        page_valid,
  input  wire logic [15:0] page_data,
  output eeeadv_reg_t      partner_ff
);

  // Only defined ability bits are kept; reserved positions stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      partner_ff <= `EEEADV_PARTNER_RST;
    end else if (page_valid) begin
      partner_ff <= page_data & `EEEADV_PARTNER_RD_MASK;
    end
  end

endmodule

// *** rtl/eeeadv_regs.sv ***
// Contract
// - Local advert resets 0x0000, or 0x0006 strapped
// - Local advert at 0x8001 drives advertised abilities
// - Bits 6 to 3 read-only, always zero
// - Bit 2 writable but always reads zero
// - Bit 1 writable, resets to strap
// - Partner ability at 0x8002 captures partner advertisement
// - Partner bit 1 reflects partner 100BASE-TX
// - Partner bits 6 to 2 report partner abilities
`timescale 1ns/100ps
`include "eeeadv_defs.svh"

module eeeadv_regs
  import eeeadv_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`EEEADV_ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      strap_eee_en,
  input  wire logic                      partner_page_valid,
  input  wire logic [15:0]               partner_page_data,
  output logic      [15:0]               local_adv_out
);

  eeeadv_apb_state_t state_ff;
  eeeadv_apb_state_t nxt_state;
  eeeadv_reg_t       local_adv_ff;
  eeeadv_reg_t       partner_eee_ability;
  logic              strap_pending_ff;
  logic              hit_local;
  logic              hit_partner;
  logic              wr_fire;
  logic [31:0]       nxt_rdata;
  eeeadv_reg_t       local_view;

  assign hit_local   = (paddr == `EEEADV_BYTE_ADDR(`EEEADV_LOCAL_ADV_ADDR));
  assign hit_partner = (paddr == `EEEADV_BYTE_ADDR(`EEEADV_PARTNER_ADDR));
  // Commit only on the edge where the master sees pready high, never one edge early
  assign wr_fire     = (state_ff == EEEADV_DONE) && pready && psel && penable && pwrite;

  // One wait state: the access phase is answered on its second cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      EEEADV_IDLE: begin
        if (psel && !penable) begin
          nxt_state = EEEADV_ACCESS;
        end
      end
      EEEADV_ACCESS: begin
        if (psel && penable) begin
          nxt_state = EEEADV_DONE;
        end
      end
      EEEADV_DONE: begin
        nxt_state = EEEADV_IDLE;
      end
      default: begin
        nxt_state = EEEADV_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= EEEADV_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Strap is caught on the first clock after reset release, not inside the reset branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pending_ff <= 1'b1;
    end else begin
      strap_pending_ff <= 1'b0;
    end
  end

  // Local advertisement; only bits 2 and 1 are storage, the rest are never written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_adv_ff <= `EEEADV_LOCAL_RST_OFF;
    end else if (strap_pending_ff) begin
      local_adv_ff <= strap_eee_en ? `EEEADV_LOCAL_RST_ON : `EEEADV_LOCAL_RST_OFF;
    end else if (wr_fire && hit_local && pstrb[0]) begin
      local_adv_ff[`EEEADV_BIT_FAST_TX] <= pwdata[`EEEADV_BIT_FAST_TX];
      local_adv_ff[`EEEADV_BIT_GIG_T]   <= pwdata[`EEEADV_BIT_GIG_T];
    end
  end

  // Bit 2 is held internally but masked out of every read
  assign local_view = local_adv_ff & `EEEADV_LOCAL_RD_MASK;

  eeeadv_partner_capture u_partner (
    .pclk       (pclk),
    .presetn    (presetn),
    .page_valid (partner_page_valid),
    .page_data  (partner_page_data),
    .partner_ff (partner_eee_ability)
  );

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_local) begin
      nxt_rdata = {16'h0000, local_view};
    end else if (hit_partner) begin
      nxt_rdata = {16'h0000, partner_eee_ability};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= (state_ff == EEEADV_ACCESS) && psel && penable && !pready;
      pslverr <= (state_ff == EEEADV_ACCESS) && psel && penable && !pready &&
                 !(hit_local || (hit_partner && !pwrite));
      prdata  <= ((state_ff == EEEADV_ACCESS) && !pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // Advertised abilities toward the autonegotiation page builder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_adv_out <= `EEEADV_LOCAL_RST_OFF;
    end else begin
      local_adv_out <= local_view;
    end
  end

endmodule

// *** tb/eeeadv_chk.sv ***
`timescale 1ns/100ps
module eeeadv_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [17:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [15:0] local_adv_out
);
  localparam logic [17:0] LA = 18'h20004, PA = 18'h20008;
  wire rd = pready && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr; pready && pwrite && paddr == LA && pstrb[0]; endsequence
  chk_one_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_err_pulse: assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_wait_state: assert property (psel && !penable |-> ##[2:3] pready) else $error("no answer");
  chk_local_mask: assert property (rd && paddr == LA |-> (prdata & ~32'h2) == 32'h0) else $error("local");
  chk_lp_mask: assert property (rd && paddr == PA |-> (prdata & ~32'h7e) == 32'h0) else $error("lp");
  chk_bad_addr: assert property (rd && paddr != LA && paddr != PA |-> pslverr && prdata == 32'h0) else $error("decode");
  chk_ro_write: assert property (pready && pwrite && paddr == PA |-> pslverr) else $error("ro write");
  chk_adv_follow: assert property (s_wr |-> ##2 local_adv_out[1] == $past(pwdata[1], 2)) else $error("adv");
  chk_adv_bits: assert property (local_adv_out[15:2] == 14'h0 && !local_adv_out[0]) else $error("adv bits");
endmodule
bind eeeadv_regs eeeadv_chk u_chk (
  .pclk          (pclk),
  .presetn       (presetn),
  .psel          (psel),
  .penable       (penable),
  .pwrite        (pwrite),
  .paddr         (paddr),
  .pwdata        (pwdata),
  .pstrb         (pstrb),
  .prdata        (prdata),
  .pready        (pready),
  .pslverr       (pslverr),
  .local_adv_out (local_adv_out)
);

// *** tb/eeeadv_partner.sv ***
`timescale 1ns/100ps
module eeeadv_partner (
  input  logic        pclk,
  output logic        page_valid = 1'h0,
  output logic [15:0] page_data = 16'h0
);
  task automatic send(input logic [15:0] d);
    @(posedge pclk);
    {page_valid, page_data} <= {1'h1, d};
    @(posedge pclk);
    {page_valid, page_data} <= {1'h0, ~d}; // Flipped so a late capture shows
  endtask
endmodule

// *** tb/eee_autoneg_advert_regs_bench.sv ***
`timescale 1ns/100ps
module eee_autoneg_advert_regs_bench;
  localparam logic [17:0] LA = 18'h20004, PA = 18'h20008;
  logic        pclk = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, presetn = 1'h0, strap_eee_en = 1'h1;
  logic        pready, pslverr, partner_page_valid;
  logic        last_err = 1'h0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic [15:0] partner_page_data, local_adv_out;
  int          n_fail = 0, num_checks = 0;
  eeeadv_regs uut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .strap_eee_en       (strap_eee_en),
    .partner_page_valid (partner_page_valid),
    .partner_page_data  (partner_page_data),
    .local_adv_out      (local_adv_out)
  );
  eeeadv_partner part (.pclk, .page_valid(partner_page_valid), .page_data(partner_page_data));
  initial forever #10 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) n_fail++;
    if (s !== e) $display("Error at %0t: seen %h, expected %h", $time, s, e);
  endtask
  task automatic xf(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1); // Latency not assumed
    last_err = pslverr;
    if (!w) chk(prdata, e);
    {psel, penable} <= 2'h0;
  endtask
  task automatic stop_test;
    $display("%0d checks, %0d mismatches", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    xf(1'h0, LA, 32'h0, 32'h2);
    chk({16'h0, local_adv_out}, 32'h2);
    xf(1'h1, LA, 32'hffffffff, 32'h0);
    xf(1'h0, LA, 32'h0, 32'h2);
    xf(1'h1, LA, 32'h0, 32'h0);
    xf(1'h0, LA, 32'h0, 32'h0);
    chk({16'h0, local_adv_out}, 32'h0);
    pstrb <= 4'he;
    xf(1'h1, LA, 32'hffffffff, 32'h0);
    pstrb <= 4'hf;
    xf(1'h0, LA, 32'h0, 32'h0);
    part.send(16'hffff);
    xf(1'h0, PA, 32'h0, 32'h7e);
    part.send(16'h0002);
    xf(1'h1, PA, 32'hffffffff, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    xf(1'h0, PA, 32'h0, 32'h2);
    xf(1'h0, 18'h0, 32'h0, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("register test done");
    {strap_eee_en, presetn} <= 2'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    xf(1'h0, LA, 32'h0, 32'h0);
    xf(1'h0, PA, 32'h0, 32'h0);
    chk({16'h0, local_adv_out}, 32'h0);
    $display("strap test done");
    stop_test;
  end
  initial begin
    #40000 n_fail++;
    stop_test;
  end
endmodule
